// >>> logic/axp_pkg.sv
/*
  Constants, types and shared functions of the serial port with
  pause/resume flow control.
  Assumes a 16x bit-rate tick from the APB clock domain.
*/
package axp_pkg;
  // ************************************************************
  // Register map and fields
  // ************************************************************
  localparam logic [7:0]  ADDR_CTRL    = 8'h00;
  localparam logic [7:0]  ADDR_STAT    = 8'h04;
  localparam logic [7:0]  ADDR_TXD     = 8'h08;
  localparam logic [7:0]  ADDR_RXD     = 8'h0c;
  localparam logic [7:0]  ADDR_BAUD    = 8'h10;
  localparam int          CTRL_DATA8   = 0;
  localparam int          CTRL_PAR_LSB = 1;
  localparam int          CTRL_STP_LSB = 4;
  localparam int          CTRL_FLOW    = 6;
  localparam int          CTRL_ESC     = 7;
  localparam logic [7:0]  CTRL_RST     = 8'h41;
  localparam int          STAT_PE      = 4;
  localparam int          STAT_FE      = 5;
  localparam int          STAT_OVR     = 6;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int          CLK_HZ       = 20000000;
  localparam int          BAUD_RST_BPS = 9600;
  localparam int          OVERSAMPLE   = 16;
  localparam logic [15:0] BAUD_DIV_RST =
    16'(CLK_HZ / (OVERSAMPLE * BAUD_RST_BPS));
  localparam logic [3:0]  RX_MID       = 4'h7;
  localparam logic [3:0]  BIT_LAST     = 4'hf;
  localparam logic [5:0]  STOP1_LAST   = 6'h0f;
  localparam logic [5:0]  STOP15_LAST  = 6'h17;
  localparam logic [5:0]  STOP2_LAST   = 6'h1f;

  // ************************************************************
  // Flow control codes
  // ************************************************************
  localparam logic [7:0]  DEVICE_CONTROL_ONE_CODE   = 8'h11;
  localparam logic [7:0]  DEVICE_CONTROL_THREE_CODE = 8'h13;

  // ************************************************************
  // Types
  // ************************************************************
  typedef enum logic [2:0] {
    PAR_NONE  = 3'h0,
    PAR_ODD   = 3'h1,
    PAR_EVEN  = 3'h2,
    PAR_MARK  = 3'h3,
    PAR_SPACE = 3'h4
  } axp_par_e;

  typedef enum logic [1:0] {
    STOP_ONE  = 2'h0,
    STOP_ONEH = 2'h1,
    STOP_TWO  = 2'h2
  } axp_stop_e;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_START = 3'h1,
    ST_DATA  = 3'h2,
    ST_PAR   = 3'h3,
    ST_STOP  = 3'h4
  } axp_st_e;

  // ************************************************************
  // Functions
  // ************************************************************
  function automatic logic par_bit(input logic [7:0] d,
                                   input logic       data8,
                                   input axp_par_e   m);
    logic ones;
    ones = ^(data8 ? d : {1'b0, d[6:0]});
    case (m)
      PAR_ODD:  return ~ones;
      PAR_EVEN: return ones;
      PAR_MARK: return 1'b1;
      default:  return 1'b0;
    endcase
  endfunction

  function automatic logic is_code(input logic [7:0] d,
                                   input logic       data8,
                                   input logic [7:0] code);
    return (d[6:0] == code[6:0]) && !(data8 && d[7]);
  endfunction
endpackage

// >>> logic/axp_rx_if.sv
/*
  Carrier between the port core and its receiver.
  Assumes both ends run on the APB clock.
*/
interface axp_rx_if;
  logic               tick;
  logic               rxd;
  logic               data8;
  axp_pkg::axp_par_e  par_mode;
  logic               stb;
  logic [7:0]         data;
  logic               par_err;
  logic               frm_err;
  modport rx   (input tick, rxd, data8, par_mode,
                output stb, data, par_err, frm_err);
  modport core (output tick, rxd, data8, par_mode,
                input stb, data, par_err, frm_err);
endinterface

// >>> logic/axp_rx.sv
/*
  Receiver: start detect, mid-bit sampling, parity and stop check.
  Assumes a 16x tick and a line input synchronous to pclk.
*/
module axp_rx (
  input  wire logic pclk,
  input  wire logic presetn,
  axp_rx_if.rx      bus
);
  axp_pkg::axp_st_e st_q, st_d;
  logic [3:0]       cnt_q, cnt_d;
  logic [2:0]       idx_q, idx_d;
  logic [7:0]       sh_q, sh_d;
  logic             pb_q, pb_d;
  logic             stb_q, stb_d;
  logic [7:0]       data_q, data_d;
  logic             pe_q, pe_d;
  logic             fe_q, fe_d;
  logic [7:0]       chr;

  always_comb begin
    st_d   = st_q;
    cnt_d  = cnt_q;
    idx_d  = idx_q;
    sh_d   = sh_q;
    pb_d   = pb_q;
    stb_d  = 1'b0;
    data_d = data_q;
    pe_d   = pe_q;
    fe_d   = fe_q;
    chr    = bus.data8 ? sh_q : {1'b0, sh_q[7:1]};
    if (bus.tick) begin
      cnt_d = cnt_q + 4'h1;
      case (st_q)
        axp_pkg::ST_IDLE: begin
          cnt_d = 4'h0;
          if (!bus.rxd) begin
            st_d = axp_pkg::ST_START;
          end
        end
        axp_pkg::ST_START: begin
          if (cnt_q == axp_pkg::RX_MID) begin
            cnt_d = 4'h0;
            idx_d = 3'h0;
            st_d  = bus.rxd ? axp_pkg::ST_IDLE : axp_pkg::ST_DATA;
          end
        end
        axp_pkg::ST_DATA: begin
          if (cnt_q == axp_pkg::BIT_LAST) begin
            sh_d  = {bus.rxd, sh_q[7:1]}; // RULE1
            idx_d = idx_q + 3'h1;
            if (idx_q == (bus.data8 ? 3'h7 : 3'h6)) begin
              st_d = (bus.par_mode == axp_pkg::PAR_NONE) ?
                     axp_pkg::ST_STOP : axp_pkg::ST_PAR; // RULE2
            end
          end
        end
        axp_pkg::ST_PAR: begin
          if (cnt_q == axp_pkg::BIT_LAST) begin
            pb_d = bus.rxd;
            st_d = axp_pkg::ST_STOP;
          end
        end
        axp_pkg::ST_STOP: begin
          // Mid stop bit: deliver and re-arm, extra stop is idle
          if (cnt_q == axp_pkg::BIT_LAST) begin
            stb_d  = 1'b1;
            data_d = chr;
            fe_d   = !bus.rxd; // RULE5
            pe_d   = (bus.par_mode != axp_pkg::PAR_NONE) &&
                     (pb_q != axp_pkg::par_bit(chr, bus.data8,
                                               bus.par_mode));
            st_d   = axp_pkg::ST_IDLE; // RULE6 RULE7
          end
        end
        default: st_d = axp_pkg::ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q   <= axp_pkg::ST_IDLE;
      cnt_q  <= 4'h0;
      idx_q  <= 3'h0;
      sh_q   <= 8'h00;
      pb_q   <= 1'b0;
      stb_q  <= 1'b0;
      data_q <= 8'h00;
      pe_q   <= 1'b0;
      fe_q   <= 1'b0;
    end else begin
      st_q   <= st_d;
      cnt_q  <= cnt_d;
      idx_q  <= idx_d;
      sh_q   <= sh_d;
      pb_q   <= pb_d;
      stb_q  <= stb_d;
      data_q <= data_d;
      pe_q   <= pe_d;
      fe_q   <= fe_d;
    end
  end

  assign bus.stb     = stb_q;
  assign bus.data    = data_q;
  assign bus.par_err = pe_q;
  assign bus.frm_err = fe_q;

  // ************************************************************
  // Checks
  // ************************************************************
  chk_rearm_half: assert property (@(posedge pclk) disable iff (!presetn)
    stb_q |-> st_q == axp_pkg::ST_IDLE) // RULE6
    else $error("receiver not re-armed at mid stop bit");
endmodule

// >>> logic/axp_port.sv
/*
  Serial port top: APB registers, bit-rate divider, transmitter,
  pause/resume flow control and escape handling.
  Assumes an APB master on pclk and a peer with matching framing.
*/
// Overview of operation
// (RULE1) Start bit low, data LSB first
// (RULE2) Odd/even parity; none skips parity slot
// (RULE3) Mark parity always sent high
// (RULE4) Space parity always sent low
// (RULE5) Stop bits high; one, 1.5, two
// (RULE6) Receiver re-arms mid final stop bit
// (RULE7) One-stop receiver accepts two stop bits
// (RULE8) Eleven-bit frame: 8 data, parity, stop
// (RULE9) Ten-bit frame variants supported
// (RULE10) Eleven-bit frames need eleven-bit peer
// (RULE11) Seven-bit codes; eighth bit zero
// (RULE12) Resume code is hex 11
// (RULE13) Pause code is hex 13
// (RULE14) Pause halts transmitter until resume
// (RULE15) Resume continues at exact paused position
// (RULE16) Resume ignored unless halted
// (RULE17) Single code acts; doubled code is data
// (RULE18) Character in flight finishes before halt
module axp_port #(
  parameter int ADDR_W = 8
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              rxd,
  output logic                   txd
);
  axp_rx_if rxif ();

  logic [7:0]       ctrl_q, ctrl_d;
  logic [15:0]      div_q, div_d;
  logic [15:0]      dcnt_q, dcnt_d;
  logic             tick_q, tick_d;
  logic [31:0]      prdata_q, prdata_d;
  logic             pready_q, pready_d;
  logic             pslverr_q, pslverr_d;
  logic [7:0]       rx_data_q, rx_data_d;
  logic             rx_vld_q, rx_vld_d;
  logic [2:0]       err_q, err_d;
  logic             halted_q, halted_d;
  logic             pend_q, pend_d;
  logic [7:0]       pchr_q, pchr_d;
  axp_pkg::axp_st_e tx_st_q, tx_st_d;
  logic [5:0]       tcnt_q, tcnt_d;
  logic [2:0]       tidx_q, tidx_d;
  logic [7:0]       tchr_q, tchr_d;
  logic [7:0]       hold_q, hold_d;
  logic             full_q, full_d;
  logic             rep_q, rep_d;
  logic             txd_q, txd_d;
  logic             data8, flow_en, esc_en, done, wr_tx, pop, hit;
  logic             deliver, pause_act, resume_act, fin;
  logic [7:0]       dchr;
  logic [5:0]       stop_last;
  axp_pkg::axp_par_e  par_mode;
  axp_pkg::axp_stop_e stop_mode;

  assign data8     = ctrl_q[axp_pkg::CTRL_DATA8];
  assign par_mode  = axp_pkg::axp_par_e'(ctrl_q[axp_pkg::CTRL_PAR_LSB +: 3]);
  assign stop_mode = axp_pkg::axp_stop_e'(ctrl_q[axp_pkg::CTRL_STP_LSB +: 2]);
  assign flow_en   = ctrl_q[axp_pkg::CTRL_FLOW];
  assign esc_en    = ctrl_q[axp_pkg::CTRL_ESC];
  assign done      = psel && penable && pready_q;
  assign wr_tx     = done && pwrite && (paddr[7:0] == axp_pkg::ADDR_TXD);
  assign pop       = done && !pwrite && (paddr[7:0] == axp_pkg::ADDR_RXD);

  assign rxif.tick     = tick_q;
  assign rxif.rxd      = rxd;
  assign rxif.data8    = data8;
  assign rxif.par_mode = par_mode;

  axp_rx u_rx (
    .pclk    (pclk),
    .presetn (presetn),
    .bus     (rxif.rx)
  );

  // ************************************************************
  // APB registers, divider, receive handling
  // ************************************************************
  always_comb begin
    ctrl_d     = ctrl_q;
    div_d      = div_q;
    dcnt_d     = dcnt_q + 16'h0001;
    tick_d     = 1'b0;
    pready_d   = psel && penable && !pready_q;
    pslverr_d  = 1'b0;
    prdata_d   = prdata_q;
    rx_data_d  = rx_data_q;
    rx_vld_d   = rx_vld_q && !pop;
    err_d      = err_q;
    halted_d   = halted_q;
    pend_d     = pend_q;
    pchr_d     = pchr_q;
    deliver    = 1'b0;
    dchr       = rxif.data;
    pause_act  = 1'b0;
    resume_act = 1'b0;
    if (dcnt_q >= div_q - 16'h0001) begin
      dcnt_d = 16'h0000;
      tick_d = 1'b1;
    end
    if (pready_d) begin
      pslverr_d = 1'b0;
      case (paddr[7:0])
        axp_pkg::ADDR_CTRL: prdata_d = {24'h0, ctrl_q};
        axp_pkg::ADDR_STAT: prdata_d = {25'h0, err_q, rx_vld_q,
                                        halted_q, full_q,
                                        tx_st_q != axp_pkg::ST_IDLE};
        axp_pkg::ADDR_TXD:  prdata_d = 32'h0;
        axp_pkg::ADDR_RXD:  prdata_d = {24'h0, rx_data_q};
        axp_pkg::ADDR_BAUD: prdata_d = {16'h0, div_q};
        default: begin
          prdata_d  = 32'h0;
          pslverr_d = 1'b1;
        end
      endcase
    end
    if (done && pwrite) begin
      if (paddr[7:0] == axp_pkg::ADDR_CTRL) begin
        ctrl_d = pwdata[7:0];
      end
      if (paddr[7:0] == axp_pkg::ADDR_BAUD) begin
        div_d = pwdata[15:0];
      end
      if (paddr[7:0] == axp_pkg::ADDR_STAT) begin
        err_d = err_q & ~pwdata[axp_pkg::STAT_PE +: 3];
      end
    end
    hit = flow_en &&
          (axp_pkg::is_code(rxif.data, data8,
                            axp_pkg::DEVICE_CONTROL_THREE_CODE) ||
           axp_pkg::is_code(rxif.data, data8,
                            axp_pkg::DEVICE_CONTROL_ONE_CODE)); // RULE11
    if (rxif.stb) begin
      if (esc_en && pend_q) begin
        // Doubled code is one literal character
        if (rxif.data == pchr_q) begin
          deliver = 1'b1;
          dchr    = pchr_q;
          pend_d  = 1'b0; // RULE17
        end else begin
          pause_act  = axp_pkg::is_code(pchr_q, data8,
                         axp_pkg::DEVICE_CONTROL_THREE_CODE);
          resume_act = axp_pkg::is_code(pchr_q, data8,
                         axp_pkg::DEVICE_CONTROL_ONE_CODE);
          pend_d     = hit;
          pchr_d     = rxif.data;
          deliver    = !hit; // RULE17
        end
      end else if (hit) begin
        if (esc_en) begin
          pend_d = 1'b1;
          pchr_d = rxif.data;
        end else begin
          pause_act  = axp_pkg::is_code(rxif.data, data8,
                         axp_pkg::DEVICE_CONTROL_THREE_CODE); // RULE13
          resume_act = axp_pkg::is_code(rxif.data, data8,
                         axp_pkg::DEVICE_CONTROL_ONE_CODE); // RULE12
        end
      end else begin
        deliver = 1'b1;
      end
      // New error sets on top of a same-cycle clear
      err_d[0] = err_d[0] || rxif.par_err;
      err_d[1] = err_d[1] || rxif.frm_err;
    end
    if (pause_act) begin
      halted_d = 1'b1; // RULE14
    end else if (resume_act && halted_q) begin
      halted_d = 1'b0; // RULE16
    end
    if (!flow_en) begin
      halted_d = 1'b0;
    end
    if (deliver) begin
      if (rx_vld_q && !pop) begin
        err_d[2] = 1'b1;
      end else begin
        rx_data_d = dchr;
        rx_vld_d  = 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q    <= axp_pkg::CTRL_RST;
      div_q     <= axp_pkg::BAUD_DIV_RST;
      dcnt_q    <= 16'h0000;
      tick_q    <= 1'b0;
      prdata_q  <= 32'h0;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      rx_data_q <= 8'h00;
      rx_vld_q  <= 1'b0;
      err_q     <= 3'h0;
      halted_q  <= 1'b0;
      pend_q    <= 1'b0;
      pchr_q    <= 8'h00;
    end else begin
      ctrl_q    <= ctrl_d;
      div_q     <= div_d;
      dcnt_q    <= dcnt_d;
      tick_q    <= tick_d;
      prdata_q  <= prdata_d;
      pready_q  <= pready_d;
      pslverr_q <= pslverr_d;
      rx_data_q <= rx_data_d;
      rx_vld_q  <= rx_vld_d;
      err_q     <= err_d;
      halted_q  <= halted_d;
      pend_q    <= pend_d;
      pchr_q    <= pchr_d;
    end
  end

  // ************************************************************
  // Transmitter
  // ************************************************************
  always_comb begin
    tx_st_d = tx_st_q;
    tcnt_d  = tcnt_q;
    tidx_d  = tidx_q;
    tchr_d  = tchr_q;
    hold_d  = hold_q;
    full_d  = full_q;
    rep_d   = rep_q;
    case (stop_mode)
      axp_pkg::STOP_ONEH: stop_last = axp_pkg::STOP15_LAST;
      axp_pkg::STOP_TWO:  stop_last = axp_pkg::STOP2_LAST;
      default:            stop_last = axp_pkg::STOP1_LAST;
    endcase
    fin = (tx_st_q == axp_pkg::ST_IDLE) ||
          (tx_st_q == axp_pkg::ST_STOP && tcnt_q == stop_last);
    if (wr_tx && !full_q) begin
      hold_d = pwdata[7:0];
      full_d = 1'b1;
    end
    if (tick_q) begin
      tcnt_d = tcnt_q + 6'h01;
      case (tx_st_q)
        axp_pkg::ST_START: begin
          if (tcnt_q[3:0] == axp_pkg::BIT_LAST) begin
            tcnt_d  = 6'h00;
            tidx_d  = 3'h0;
            tx_st_d = axp_pkg::ST_DATA;
          end
        end
        axp_pkg::ST_DATA: begin
          if (tcnt_q[3:0] == axp_pkg::BIT_LAST) begin
            tcnt_d = 6'h00;
            tidx_d = tidx_q + 3'h1;
            if (tidx_q == (data8 ? 3'h7 : 3'h6)) begin // RULE8 RULE9
              tx_st_d = (par_mode == axp_pkg::PAR_NONE) ?
                        axp_pkg::ST_STOP : axp_pkg::ST_PAR; // RULE2
            end
          end
        end
        axp_pkg::ST_PAR: begin
          if (tcnt_q[3:0] == axp_pkg::BIT_LAST) begin
            tcnt_d  = 6'h00;
            tx_st_d = axp_pkg::ST_STOP;
          end
        end
        default: tx_st_d = tx_st_q;
      endcase
      // New frames start only at a frame boundary and not halted
      if (fin) begin // RULE18 RULE10
        tcnt_d  = 6'h00;
        tx_st_d = axp_pkg::ST_IDLE;
        if (!halted_q && (rep_q || full_q)) begin // RULE14 RULE15
          tx_st_d = axp_pkg::ST_START;
          if (rep_q) begin
            rep_d = 1'b0; // RULE17
          end else begin
            tchr_d = hold_q;
            full_d = 1'b0;
            rep_d  = esc_en && flow_en &&
                     (axp_pkg::is_code(hold_q, data8,
                        axp_pkg::DEVICE_CONTROL_ONE_CODE) ||
                      axp_pkg::is_code(hold_q, data8,
                        axp_pkg::DEVICE_CONTROL_THREE_CODE));
          end
        end
      end
    end
    case (tx_st_d)
      axp_pkg::ST_START: txd_d = 1'b0; // RULE1
      axp_pkg::ST_DATA:  txd_d = tchr_d[tidx_d]; // RULE1
      axp_pkg::ST_PAR:   txd_d = axp_pkg::par_bit(tchr_d, data8,
                                                  par_mode); // RULE3 RULE4
      default:           txd_d = 1'b1; // RULE5
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_st_q <= axp_pkg::ST_IDLE;
      tcnt_q  <= 6'h00;
      tidx_q  <= 3'h0;
      tchr_q  <= 8'h00;
      hold_q  <= 8'h00;
      full_q  <= 1'b0;
      rep_q   <= 1'b0;
      txd_q   <= 1'b1;
    end else begin
      tx_st_q <= tx_st_d;
      tcnt_q  <= tcnt_d;
      tidx_q  <= tidx_d;
      tchr_q  <= tchr_d;
      hold_q  <= hold_d;
      full_q  <= full_d;
      rep_q   <= rep_d;
      txd_q   <= txd_d;
    end
  end

  assign prdata  = prdata_q;
  assign pready  = pready_q;
  assign pslverr = pslverr_q;
  assign txd     = txd_q;

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_start_low: assert property ( // RULE1
    $rose(tx_st_q == axp_pkg::ST_START) |-> !txd_q [*8])
    else $error("start bit not low");
  chk_lsb_first: assert property ( // RULE1
    tx_st_q == axp_pkg::ST_DATA |-> txd_q == tchr_q[tidx_q])
    else $error("data bit order wrong");
  chk_parity_val: assert property ( // RULE2
    tx_st_q == axp_pkg::ST_PAR && par_mode == axp_pkg::PAR_ODD
    |-> ^{txd_q, (data8 ? tchr_q : {1'b0, tchr_q[6:0]})})
    else $error("odd parity wrong");
  chk_mark_par: assert property ( // RULE3
    tx_st_q == axp_pkg::ST_PAR && par_mode == axp_pkg::PAR_MARK
    |-> txd_q)
    else $error("mark parity not high");
  chk_space_par: assert property ( // RULE4
    tx_st_q == axp_pkg::ST_PAR && par_mode == axp_pkg::PAR_SPACE
    |-> !txd_q)
    else $error("space parity not low");
  chk_stop_mark: assert property ( // RULE5
    tx_st_q == axp_pkg::ST_STOP || tx_st_q == axp_pkg::ST_IDLE |-> txd_q)
    else $error("stop bit not high");
  chk_halt_hold: assert property ( // RULE14
    halted_q && tx_st_q == axp_pkg::ST_IDLE |=> tx_st_q == axp_pkg::ST_IDLE)
    else $error("transmitter started while halted");
  chk_no_trunc: assert property ( // RULE18
    $rose(halted_q) && tx_st_q == axp_pkg::ST_DATA
    |=> tx_st_q != axp_pkg::ST_IDLE)
    else $error("frame cut by pause");
  chk_resume_gate: assert property ( // RULE16
    !halted_q && !pause_act |=> !halted_q)
    else $error("halt without pause");
  chk_pause_acts: assert property ( // RULE13
    pause_act && flow_en |=> halted_q)
    else $error("pause not acted upon");

  cov_halt:   cover property ($rose(halted_q));
  cov_resume: cover property ($fell(halted_q));
  cov_rx_chr: cover property (rxif.stb && !rxif.par_err);
  cov_par_tx: cover property (tx_st_q == axp_pkg::ST_PAR);
endmodule

// >>> test/axp_peer.sv
/*
  Remote serial peer: sends frames on rxd, decodes frames on txd.
  Assumes 8 sampled bits plus one after them, fixed bit length.
*/
module axp_peer #(
  parameter int BIT = 32
) (
  input  wire logic       pclk,
  input  wire logic       txd,
  output logic            rxd,
  output logic            got,
  output logic [8:0]      got_d
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****
  // Sender
  // ****
  initial rxd = 1'b1;
  task automatic send(input logic [7:0] d, input int stops);
    logic [8:0] f;
    f = {d, 1'b0};
    for (int i = 0; i < 9 + stops; i++) begin
      @(posedge pclk);
      rxd <= (i < 9) ? f[i] : 1'b1;
      repeat (BIT - 1) @(posedge pclk);
    end
  endtask
  // ****
  // Decoder, samples mid-bit
  // ****
  initial begin
    got = 1'b0;
    got_d = 9'h0;
    forever begin
      @(negedge txd);
      repeat (BIT / 2) @(posedge pclk);
      for (int i = 0; i < 9; i++) begin
        repeat (BIT) @(posedge pclk);
        got_d[i] = txd;
      end
      got = 1'b1;
      @(posedge pclk);
      got = 1'b0;
    end
  end
endmodule

// >>> test/axp_port_bench.sv
/*
  Self-checking bench of the serial port: APB master, peer model,
  queue of expected frames. Assumes axp_pkg and axp_peer.
*/
module axp_port_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        pclk, presetn, psel, penable, pwrite;
  logic        pready, pslverr, rxd, txd, got, err, pb, d8;
  logic [7:0]  paddr, c;
  logic [7:0]  tab[3] = '{8'h5a, 8'h3c, 8'h66};
  logic [31:0] pwdata, prdata, rd;
  logic [8:0]  got_d;
  logic [8:0]  exp_q[$];
  int          num_errors, check_count, seed, m;

  axp_port dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .rxd, .txd);
  axp_peer #(.BIT(32)) peer (.pclk, .txd, .rxd, .got, .got_d);

  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  // ****
  // Checking and closing
  // ****
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      num_errors++;
      $display("mismatch at %0t: saw %h want %h", $time, s, e);
    end
  endtask
  task automatic close_out();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic hung();
    chk(32'h0, 32'h1);
    close_out();
  endtask
  // ****
  // APB master and helpers
  // ****
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1)
      hung();
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wait_stat(input int b, input logic v);
    int n;
    n = 0;
    do begin
      apb(1'b0, axp_pkg::ADDR_STAT, 32'h0);
      n++;
    end while (rd[b] !== v && n < 2000);
    if (rd[b] !== v)
      hung();
  endtask
  task automatic tx(input logic [7:0] d, input logic [8:0] e);
    wait_stat(1, 1'b0);
    exp_q.push_back(e);
    apb(1'b1, axp_pkg::ADDR_TXD, {24'h0, d});
  endtask
  task automatic drain();
    int n;
    for (n = 0; n < 5000 && exp_q.size() > 0; n++)
      @(posedge pclk);
    if (exp_q.size() > 0)
      hung();
    // Let the longest stop tail finish before a mode change
    repeat (128) @(posedge pclk);
  endtask
  // ****
  // Frame monitor
  // ****
  always @(posedge got) begin
    if (exp_q.size() == 0)
      chk(32'(got_d), 32'hffffffff);
    else
      chk(32'(got_d), 32'(exp_q.pop_front()));
  end
  // ****
  // Main sequence
  // ****
  initial begin
    seed = 32'hd49e67a2;
    num_errors = 0;
    check_count = 0;
    {presetn, psel, penable, pwrite} = 4'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk(txd, 1'b1);
    apb(1'b0, axp_pkg::ADDR_CTRL, 32'h0);
    chk(rd, 32'(axp_pkg::CTRL_RST));
    apb(1'b0, axp_pkg::ADDR_BAUD, 32'h0);
    chk(rd, 32'(axp_pkg::BAUD_DIV_RST));
    apb(1'b0, 8'h24, 32'h0);
    chk(err, 1'b1);
    apb(1'b1, axp_pkg::ADDR_BAUD, 32'h2);
    for (int k = 0; k < 10; k++) begin
      m = k % 5;
      d8 = k < 5;
      apb(1'b1, axp_pkg::ADDR_CTRL,
          32'(64 + m * 2 + (d8 ? m % 3 * 16 + 1 : 32)));
      repeat (2) begin
        c = 8'($random(seed)) & 8'h7f | 8'h20;
        pb = (m == 1) ? ~^c : (m == 2) ? ^c : (m != 4);
        tx(c, d8 ? {pb, c} : {1'b1, pb, c[6:0]});
      end
      drain();
    end
    apb(1'b1, axp_pkg::ADDR_CTRL, 32'h41);
    fork
      begin
        peer.send(tab[0], 2);
        peer.send(tab[1], 1);
        peer.send(tab[2], 1);
      end
      for (int i = 0; i < 3; i++) begin
        wait_stat(3, 1'b1);
        apb(1'b0, axp_pkg::ADDR_RXD, 32'h0);
        chk(rd, {24'h0, tab[i]});
      end
    join
    tx(8'h61, 9'h161);
    peer.send(axp_pkg::DEVICE_CONTROL_THREE_CODE, 1);
    wait_stat(2, 1'b1);
    tx(8'h4d, 9'h14d);
    repeat (500) @(posedge pclk);
    chk(exp_q.size(), 1);
    peer.send(axp_pkg::DEVICE_CONTROL_ONE_CODE, 1);
    drain();
    chk(exp_q.size(), 0);
    peer.send(axp_pkg::DEVICE_CONTROL_ONE_CODE, 1);
    repeat (40) @(posedge pclk);
    apb(1'b0, axp_pkg::ADDR_STAT, 32'h0);
    chk(rd[3:2], 2'b00);
    apb(1'b1, axp_pkg::ADDR_CTRL, 32'hc1);
    exp_q.push_back(9'h113);
    tx(8'h13, 9'h113);
    drain();
    repeat (400) @(posedge pclk);
    chk(exp_q.size(), 0);
    // Doubled code with escape on, single code with flow off: both data
    for (int j = 0; j < 2; j++) begin
      apb(1'b1, axp_pkg::ADDR_CTRL, j ? 32'h01 : 32'hc1);
      repeat (2 - j) peer.send(axp_pkg::DEVICE_CONTROL_THREE_CODE, 1);
      wait_stat(3, 1'b1);
      chk(rd[2], 1'b0);
      apb(1'b0, axp_pkg::ADDR_RXD, 32'h0);
      chk(rd, {24'h0, axp_pkg::DEVICE_CONTROL_THREE_CODE});
    end
    close_out();
  end
endmodule
